/* File: src/qsp_map.svh */
// Constants for the shared quadrature/SPI pin multiplexer.
// Assumes inclusion by bare name from the pin multiplexer design file.
`ifndef QSP_MAP_SVH
`define QSP_MAP_SVH

`define QSP_PIN_COUNT      3
`define QSP_PIN_PHASE_A    0
`define QSP_PIN_PHASE_B    1
`define QSP_PIN_INDEX      2
`define QSP_PULLUP_BIT_A   0
`define QSP_PULLUP_BIT_B   1
`define QSP_PULLUP_BIT_IDX 2
`define QSP_PULLUP_RESET   3'h7
`define QSP_IDLE_LEVEL     1'b1
`define QSP_SYNC_STAGES    2

`endif

/* File: src/qsp_pin_mux.sv */
// Pin multiplexer for three shared pins: quadrature inputs, timer B channels,
// second SPI and port C GPIO. Control bits arrive as plain ports on clk_sys.
// Assumes pin pads resolve level from pin_out and active-low pin_oe_n.
`timescale 1ns/10ps
`include "qsp_map.svh"

// Function
// - With the phase-A alternate select set, the phase-A pin carries the SPI clock.
// - With the phase-B alternate select set, the phase-B pin carries SPI master-out data.
// - With the index alternate select set, the index pin carries SPI master-in data.
// - On the full variant, after reset, the pins feed the quadrature decoder inputs.
// - Clearing pull-up bit 0 of port C turns off the phase-A pin pull-up.
// - Clearing pull-up bit 1 of port C turns off the phase-B pin pull-up.
// - Clearing pull-up bit 2 of port C turns off the index pin pull-up.
// - In SPI master mode the clock pin is an output driving the slaves.
// - In SPI slave mode the clock pin is an input used as data clock.
// - The master presents each MOSI bit half a clock before the slave samples it.
// - The slave presents each MISO bit half a clock before the master samples it.
// - An unselected slave holds MISO in high impedance.
// - As GPIO each pin is an input or an output independently of the others.
// - Slave select arbitrates masters in master mode and selects in slave mode.
module qsp_pin_mux (
  input  wire logic       clk_sys,
  input  wire logic       reset_n,
  input  wire logic [2:0] pin_in,
  output logic      [2:0] pin_out,
  output logic      [2:0] pin_oe_n,
  output logic      [2:0] pin_pullup_en,
  input  wire logic       variant_full,
  input  wire logic       cfg_commit,
  input  wire logic       phase_a_alt_select,
  input  wire logic       phase_b_alt_select,
  input  wire logic       select_a,
  input  wire logic [2:0] port_c_pullup_reg,
  input  wire logic [2:0] port_c_gpio_sel,
  input  wire logic [2:0] port_c_dir_out,
  input  wire logic [2:0] port_c_data_out,
  output logic      [2:0] port_c_pin_in,
  input  wire logic [2:0] timer_b_drive,
  input  wire logic [2:0] timer_b_drive_en,
  output logic      [2:0] timer_b_sample,
  output logic            quad_phase_a_in,
  output logic            quad_phase_b_in,
  output logic            quad_index_in,
  input  wire logic       spi_master_mode,
  input  wire logic       spi_slave_select_n,
  input  wire logic       spi_second_clock_drive,
  input  wire logic       spi_second_master_out_drive,
  input  wire logic       spi_second_master_in_drive,
  output logic            spi_second_clock,
  output logic            spi_second_master_out,
  output logic            spi_second_master_in,
  output logic            spi_mode_fault,
  output logic            spi_slave_selected,
  output logic            pins_configured
);

  localparam int NPIN = `QSP_PIN_COUNT;

  // Routing choice for one pin; GPIO wins over SPI, SPI over quadrature
  function automatic qsp_pkg::qsp_mode_e pin_mode(input logic gpio_sel,
                                                  input logic alt_sel,
                                                  input qsp_pkg::qsp_state_e st);
    if (st != qsp_pkg::ST_RUN) begin
      pin_mode = qsp_pkg::MODE_NONE;
    end else if (gpio_sel) begin
      pin_mode = qsp_pkg::MODE_GPIO;
    end else if (alt_sel) begin
      pin_mode = qsp_pkg::MODE_SPI;
    end else begin
      pin_mode = qsp_pkg::MODE_QUAD;
    end
  endfunction : pin_mode

  // Synchronised pins (bits 2:0) and slave select (bit 3)
  logic [3:0] sync_q;
  qsp_sync #(
    .WIDTH       (4)
  ) u_sync (
    .clk_sys     (clk_sys),
    .reset_n     (reset_n),
    .async_in    ({spi_slave_select_n, pin_in}),
    .sync_out    (sync_q)
  );

  logic [2:0]          pin_q;
  logic                ss_active;
  logic [2:0]          alt_sel;
  qsp_pkg::qsp_state_e state;
  qsp_pkg::qsp_state_e next_state;

  assign pin_q     = sync_q[2:0];
  assign ss_active = !sync_q[3];
  assign alt_sel   = {select_a, phase_b_alt_select, phase_a_alt_select};

  // Variant strap is caught by a clocked step after reset release
  always_comb begin
    next_state = state;
    case (state)
      qsp_pkg::ST_STRAP: begin
        next_state = variant_full ? qsp_pkg::ST_RUN : qsp_pkg::ST_UNCONFIG;
      end
      qsp_pkg::ST_UNCONFIG: begin
        if (cfg_commit) begin
          next_state = qsp_pkg::ST_RUN;
        end
      end
      qsp_pkg::ST_RUN: begin
        next_state = qsp_pkg::ST_RUN;
      end
      default: begin
        next_state = qsp_pkg::ST_STRAP;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state <= qsp_pkg::ST_STRAP;
    end else begin
      state <= next_state;
    end
  end

  logic [2:0] next_pin_out;
  logic [2:0] next_pin_oe_n;
  logic [2:0] next_pullup;
  logic [2:0] next_port_c_in;
  logic [2:0] next_timer_in;
  logic [2:0] next_quad;
  logic [2:0] next_spi_in;
  logic       next_fault;
  logic       next_slave_sel;
  logic       next_configured;
  logic [2:0] spi_drv;
  logic [2:0] spi_drv_en;
  logic [2:0] quad_reg;
  logic [2:0] spi_reg;

  always_comb begin
    qsp_pkg::qsp_mode_e mode;
    mode            = qsp_pkg::MODE_NONE;
    spi_drv         = {spi_second_master_in_drive, spi_second_master_out_drive,
                       spi_second_clock_drive};
    spi_drv_en[`QSP_PIN_PHASE_A] = spi_master_mode;
    spi_drv_en[`QSP_PIN_PHASE_B] = spi_master_mode;
    spi_drv_en[`QSP_PIN_INDEX]   = !spi_master_mode && ss_active;
    next_fault      = spi_master_mode && ss_active;
    next_slave_sel  = !spi_master_mode && ss_active;
    next_configured = (next_state == qsp_pkg::ST_RUN);
    next_pullup     = port_c_pullup_reg;
    next_port_c_in  = pin_q;
    next_pin_out    = {NPIN{`QSP_IDLE_LEVEL}};
    next_pin_oe_n   = '1;
    next_timer_in   = {NPIN{`QSP_IDLE_LEVEL}};
    next_quad       = {NPIN{`QSP_IDLE_LEVEL}};
    next_spi_in     = {NPIN{`QSP_IDLE_LEVEL}};
    for (int i = 0; i < NPIN; i++) begin
      mode = pin_mode(port_c_gpio_sel[i], alt_sel[i], state);
      case (mode)
        qsp_pkg::MODE_QUAD: begin
          next_quad[i]     = pin_q[i];
          next_timer_in[i] = pin_q[i];
          next_pin_out[i]  = timer_b_drive[i];
          next_pin_oe_n[i] = !timer_b_drive_en[i];
        end
        qsp_pkg::MODE_SPI: begin
          // Data and clock share one register stage, keeping half-cycle setup
          next_spi_in[i]   = spi_drv_en[i] ? `QSP_IDLE_LEVEL : pin_q[i];
          next_pin_out[i]  = spi_drv[i];
          next_pin_oe_n[i] = !spi_drv_en[i];
        end
        qsp_pkg::MODE_GPIO: begin
          next_pin_out[i]  = port_c_data_out[i];
          next_pin_oe_n[i] = !port_c_dir_out[i];
        end
        default: begin
          next_pin_oe_n[i] = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pin_out            <= {NPIN{`QSP_IDLE_LEVEL}};
      pin_oe_n           <= 3'h7;
      pin_pullup_en      <= `QSP_PULLUP_RESET;
      port_c_pin_in      <= 3'h7;
      timer_b_sample     <= 3'h7;
      quad_reg           <= 3'h7;
      spi_reg            <= 3'h7;
      spi_mode_fault     <= 1'b0;
      spi_slave_selected <= 1'b0;
      pins_configured    <= 1'b0;
    end else begin
      pin_out            <= next_pin_out;
      pin_oe_n           <= next_pin_oe_n;
      pin_pullup_en      <= next_pullup;
      port_c_pin_in      <= next_port_c_in;
      timer_b_sample     <= next_timer_in;
      quad_reg           <= next_quad;
      spi_reg            <= next_spi_in;
      spi_mode_fault     <= next_fault;
      spi_slave_selected <= next_slave_sel;
      pins_configured    <= next_configured;
    end
  end

  assign quad_phase_a_in       = quad_reg[`QSP_PIN_PHASE_A];
  assign quad_phase_b_in       = quad_reg[`QSP_PIN_PHASE_B];
  assign quad_index_in         = quad_reg[`QSP_PIN_INDEX];
  assign spi_second_clock      = spi_reg[`QSP_PIN_PHASE_A];
  assign spi_second_master_out = spi_reg[`QSP_PIN_PHASE_B];
  assign spi_second_master_in  = spi_reg[`QSP_PIN_INDEX];

  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  logic run_q;
  assign run_q = (state == qsp_pkg::ST_RUN);

  sequence s_alt_a_master;
    run_q && phase_a_alt_select && !port_c_gpio_sel[0] && spi_master_mode;
  endsequence

  sequence s_index_slave_idle;
    run_q && select_a && !port_c_gpio_sel[2] && !spi_master_mode && !ss_active;
  endsequence

  chk_clock_pin_drive: assert property (
    s_alt_a_master |=> !pin_oe_n[0] && pin_out[0] == $past(spi_second_clock_drive))
    else $error("phase-A pin not driving SPI clock");

  chk_mosi_pin_drive: assert property (
    run_q && phase_b_alt_select && !port_c_gpio_sel[1] && spi_master_mode
    |=> !pin_oe_n[1] && pin_out[1] == $past(spi_second_master_out_drive))
    else $error("phase-B pin not driving MOSI");

  chk_miso_hiz: assert property (
    s_index_slave_idle |=> pin_oe_n[2])
    else $error("unselected slave drives MISO");

  chk_clock_slave_in: assert property (
    run_q && phase_a_alt_select && !port_c_gpio_sel[0] && !spi_master_mode
    |=> pin_oe_n[0] && spi_second_clock == $past(pin_q[0]))
    else $error("slave clock not taken from pin");

  chk_strap_full: assert property (
    state == qsp_pkg::ST_STRAP && variant_full |=> run_q ##1 pins_configured)
    else $error("full variant not routed after reset");

  chk_reduced_hold: assert property (
    state == qsp_pkg::ST_UNCONFIG && !cfg_commit |=> pin_oe_n == 3'h7 && !pins_configured)
    else $error("reduced variant pin active before configuration");

  chk_pullup_clear: assert property (
    !port_c_pullup_reg[`QSP_PULLUP_BIT_A] |=> !pin_pullup_en[0])
    else $error("phase-A pull-up not cleared");

  chk_pullup_b_clear: assert property (
    !port_c_pullup_reg[`QSP_PULLUP_BIT_B] |=> !pin_pullup_en[1])
    else $error("phase-B pull-up not cleared");

  chk_pullup_idx_clear: assert property (
    !port_c_pullup_reg[`QSP_PULLUP_BIT_IDX] |=> !pin_pullup_en[2])
    else $error("index pull-up not cleared");

  chk_strap_quiet: assert property (
    state == qsp_pkg::ST_STRAP |=> pin_oe_n == 3'h7)
    else $error("pin driven before variant strap resolved");

  chk_gpio_dir: assert property (
    run_q && port_c_gpio_sel[1] |=> pin_oe_n[1] == !$past(port_c_dir_out[1]))
    else $error("GPIO direction not honoured");

  chk_quad_default: assert property (
    run_q && !alt_sel[2] && !port_c_gpio_sel[2]
    |=> quad_index_in == $past(pin_q[2]) && spi_second_master_in)
    else $error("index pin left its quadrature function");

  chk_master_arb: assert property (
    spi_master_mode && ss_active |=> spi_mode_fault && !spi_slave_selected)
    else $error("master arbitration not flagged");

endmodule : qsp_pin_mux

/* File: src/qsp_pkg.sv */
// Types for the shared quadrature/SPI pin multiplexer.
// Assumes nothing beyond a SystemVerilog compiler.
package qsp_pkg;

  typedef enum logic [1:0] {
    MODE_NONE,
    MODE_QUAD,
    MODE_SPI,
    MODE_GPIO
  } qsp_mode_e;

  typedef enum logic [1:0] {
    ST_STRAP,
    ST_UNCONFIG,
    ST_RUN
  } qsp_state_e;

endpackage : qsp_pkg

/* File: src/qsp_sync.sv */
// Two-stage level synchroniser for pin inputs.
// Assumes asynchronous inputs and a single clock domain.
`timescale 1ns/10ps
module qsp_sync #(
  parameter int WIDTH = 4
) (
  input  wire logic             clk_sys,
  input  wire logic             reset_n,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] next_stage1;
  logic [WIDTH-1:0] next_sync_out;

  always_comb begin
    next_stage1   = async_in;
    next_sync_out = stage1;
  end

  // Reset value is a constant parameter-free all-ones (pulled-up idle)
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      stage1   <= '1;
      sync_out <= '1;
    end else begin
      stage1   <= next_stage1;
      sync_out <= next_sync_out;
    end
  end

endmodule : qsp_sync

/* File: tb/qsp_peer.sv */
// Far-side model: quadrature encoder or SPI peer on the three shared pads.
// Assumes the mux drives pad i while dut_oe_n[i] is low.
`timescale 1ns/10ps
module qsp_peer (
  input  wire logic       clk_sys,
  input  wire logic [2:0] dut_out,
  input  wire logic [2:0] dut_oe_n,
  input  wire logic [2:0] pullup_en,
  input  wire logic [2:0] drive_val,
  input  wire logic [2:0] drive_en,
  input  wire logic       peer_sel_n,
  output logic      [2:0] pad
);
  logic [2:0] churn;
  logic [2:0] own_en;
  initial churn = 3'h5;
  // Floating pad without pull-up must not look stable
  always @(posedge clk_sys) churn <= ~churn;
  assign own_en = {drive_en[2] & ~peer_sel_n, drive_en[1:0]};
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      if (!dut_oe_n[i]) pad[i] = dut_out[i];
      else if (own_en[i]) pad[i] = drive_val[i];
      else if (pullup_en[i]) pad[i] = 1'b1;
      else pad[i] = churn[i];
    end
  end
endmodule : qsp_peer

/* File: tb/qsp_pin_mux_bench.sv */
// Self-checking bench for the shared-pin multiplexer.
// Assumes qsp_pin_mux and qsp_peer compiled before it.
`timescale 1ns/10ps
module qsp_pin_mux_bench;
  typedef struct packed {
    logic [2:0] alt;
    logic       mst;
    logic [2:0] gpio;
    logic [2:0] dir;
    logic [2:0] dat;
    logic [2:0] ten;
    logic [2:0] tmr;
    logic [2:0] spi;
    logic [2:0] pu;
    logic [2:0] oe_n;
    logic [2:0] out;
  } qsp_row_s;
  logic       clk_sys, reset_n, variant_full, cfg_commit, mst, sel_n, peer_sel_n;
  logic [2:0] alt, gpio, dir, dat, ten, tmr, spi, pu, pv, pe;
  logic [2:0] pad, p_out, p_oe_n, p_pu, c_in, t_smp;
  logic       qa, qb, qi, s_clk, s_mo, s_mi, fault, selected, configured;
  int         n_mismatch;
  int         comparisons;
  qsp_row_s   rows [7] = '{
    '{3'h0, 1'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h7, 3'h7, 3'h0},
    '{3'h0, 1'h0, 3'h0, 3'h0, 3'h0, 3'h7, 3'h5, 3'h0, 3'h5, 3'h0, 3'h5},
    '{3'h7, 1'h1, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h5, 3'h2, 3'h4, 3'h1},
    '{3'h7, 1'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h7, 3'h0, 3'h7, 3'h0},
    '{3'h0, 1'h0, 3'h7, 3'h5, 3'h1, 3'h7, 3'h2, 3'h0, 3'h3, 3'h2, 3'h1},
    '{3'h7, 1'h1, 3'h2, 3'h2, 3'h2, 3'h0, 3'h0, 3'h0, 3'h7, 3'h4, 3'h2},
    '{3'h1, 1'h1, 3'h0, 3'h0, 3'h0, 3'h7, 3'h6, 3'h1, 3'h6, 3'h0, 3'h7}};

  always #25 clk_sys = ~clk_sys;

  qsp_pin_mux dut (
    .clk_sys(clk_sys), .reset_n(reset_n), .pin_in(pad), .pin_out(p_out),
    .pin_oe_n(p_oe_n), .pin_pullup_en(p_pu), .variant_full(variant_full),
    .cfg_commit(cfg_commit), .phase_a_alt_select(alt[0]), .phase_b_alt_select(alt[1]),
    .select_a(alt[2]), .port_c_pullup_reg(pu), .port_c_gpio_sel(gpio),
    .port_c_dir_out(dir), .port_c_data_out(dat), .port_c_pin_in(c_in),
    .timer_b_drive(tmr), .timer_b_drive_en(ten), .timer_b_sample(t_smp),
    .quad_phase_a_in(qa), .quad_phase_b_in(qb), .quad_index_in(qi),
    .spi_master_mode(mst), .spi_slave_select_n(sel_n),
    .spi_second_clock_drive(spi[0]), .spi_second_master_out_drive(spi[1]),
    .spi_second_master_in_drive(spi[2]), .spi_second_clock(s_clk),
    .spi_second_master_out(s_mo), .spi_second_master_in(s_mi),
    .spi_mode_fault(fault), .spi_slave_selected(selected), .pins_configured(configured));

  qsp_peer peer (
    .clk_sys(clk_sys), .dut_out(p_out), .dut_oe_n(p_oe_n), .pullup_en(p_pu),
    .drive_val(pv), .drive_en(pe), .peer_sel_n(peer_sel_n), .pad(pad));

  task automatic check(input string what, input logic [2:0] exp, input logic [2:0] got);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask : settle

  task automatic do_reset(input logic full);
    @(posedge clk_sys);
    reset_n <= 1'b0;
    variant_full <= full;
    repeat (4) @(posedge clk_sys);
    reset_n <= 1'b1;
  endtask : do_reset

  task automatic end_of_test();
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_of_test

  initial begin
    clk_sys = 1'b0; reset_n = 1'b0; variant_full = 1'b1; cfg_commit = 1'b0; mst = 1'b0;
    sel_n = 1'b1; peer_sel_n = 1'b1; alt = 3'h0; gpio = 3'h0; dir = 3'h0; dat = 3'h0;
    ten = 3'h0; tmr = 3'h0; spi = 3'h0; pu = 3'h7; pv = 3'h0; pe = 3'h0;
    n_mismatch = 0; comparisons = 0;
    settle(3);
    check("oe_n in reset", 3'h7, p_oe_n);
    check("pullup in reset", 3'h7, p_pu);
    @(posedge clk_sys);
    reset_n <= 1'b1;
    settle(3);
    check("configured full", 3'h1, {2'h0, configured});
    foreach (rows[i]) begin
      @(posedge clk_sys);
      alt <= rows[i].alt; mst <= rows[i].mst; gpio <= rows[i].gpio; dir <= rows[i].dir;
      dat <= rows[i].dat; ten <= rows[i].ten; tmr <= rows[i].tmr; spi <= rows[i].spi;
      pu <= rows[i].pu;
      settle(4);
      check("pin_oe_n", rows[i].oe_n, p_oe_n);
      check("pin_out", rows[i].out & ~rows[i].oe_n, p_out & ~rows[i].oe_n);
      check("pin_pullup_en", rows[i].pu, p_pu);
    end
    // Encoder drives pads, mux back in decoder mode
    @(posedge clk_sys);
    alt <= 3'h0; gpio <= 3'h0; ten <= 3'h0; pu <= 3'h7; pv <= 3'h2; pe <= 3'h7;
    peer_sel_n <= 1'b0;
    settle(5);
    check("quad inputs", 3'h2, {qi, qb, qa});
    check("timer_b_sample", 3'h2, t_smp);
    check("port_c_pin_in", 3'h2, c_in);
    // Selected slave: peer clocks in, mux drives MISO
    @(posedge clk_sys);
    alt <= 3'h7; mst <= 1'b0; sel_n <= 1'b0; spi <= 3'h0; pe <= 3'h3; pv <= 3'h2;
    settle(5);
    check("slave oe_n", 3'h3, p_oe_n);
    check("slave miso", 3'h0, {2'h0, p_out[2]});
    check("slave selected", 3'h1, {2'h0, selected});
    check("slave clk mosi", 3'h2, {1'h0, s_mo, s_clk});
    // Master with select low is an arbitration fault
    @(posedge clk_sys);
    mst <= 1'b1; pe <= 3'h4; pv <= 3'h0;
    settle(5);
    check("mode fault", 3'h1, {2'h0, fault});
    check("master miso in", 3'h0, {2'h0, s_mi});
    // Reduced variant stays unrouted until committed
    @(posedge clk_sys);
    alt <= 3'h0; sel_n <= 1'b1; ten <= 3'h7; tmr <= 3'h0; pe <= 3'h0;
    do_reset(1'b0);
    settle(1);
    check("strap oe_n", 3'h7, p_oe_n);
    settle(2);
    check("unconfigured", 3'h0, {2'h0, configured});
    check("unconfigured oe_n", 3'h7, p_oe_n);
    @(posedge clk_sys);
    cfg_commit <= 1'b1;
    settle(3);
    check("committed", 3'h1, {2'h0, configured});
    check("committed oe_n", 3'h0, p_oe_n);
    end_of_test();
  end

  initial begin
    #200us;
    n_mismatch++;
    end_of_test();
  end
endmodule : qsp_pin_mux_bench
